// ### src/ring_gen_pkg.sv
// Constants, register map and state codes for the ringing waveform generator.
// Assumes a 100 MHz system clock and 8 kHz / 1 kHz sample strobes on that clock.
package ring_gen_pkg;

  // Direct register addresses
  localparam logic [7:0] ADDR_IND_DATA_LO = 8'h1c;
  localparam logic [7:0] ADDR_IND_DATA_HI = 8'h1d;
  localparam logic [7:0] ADDR_IND_ADDR = 8'h1e;
  localparam logic [7:0] ADDR_IND_CMD = 8'h1f;
  localparam logic [7:0] ADDR_RING_CONTROL = 8'h22;
  localparam logic [7:0] ADDR_ON_TIMER_LO = 8'h30;
  localparam logic [7:0] ADDR_ON_TIMER_HI = 8'h31;
  localparam logic [7:0] ADDR_OFF_TIMER_LO = 8'h32;
  localparam logic [7:0] ADDR_OFF_TIMER_HI = 8'h33;
  localparam logic [7:0] ADDR_LINEFEED = 8'h40;
  localparam logic [7:0] ADDR_HIGH_BATTERY = 8'h4a;
  localparam logic [7:0] ADDR_EXT_CONTROL = 8'h6c;

  // Indirect register addresses
  localparam logic [7:0] IND_OFFSET = 8'h13;
  localparam logic [7:0] IND_FREQ = 8'h14;
  localparam logic [7:0] IND_AMP = 8'h15;
  localparam logic [7:0] IND_PHASE = 8'h16;
  localparam logic [7:0] IND_HEADROOM = 8'h28;

  // Field positions
  localparam int BIT_SHAPE = 0;
  localparam int BIT_OFFSET_EN = 1;
  localparam int BIT_OSC_EN = 2;
  localparam int BIT_OFF_EN = 3;
  localparam int BIT_ON_EN = 4;
  localparam int BIT_BOOST_EN = 7;
  localparam int BIT_IND_WRITE = 0;

  // Linefeed codes
  localparam logic [2:0] LF_RINGING = 3'h4;
  localparam logic [2:0] LF_ONHOOK_TX = 3'h2;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Current limit boost duration
  localparam int CLK_PERIOD_NS = 10;
  localparam int BOOST_TIME_NS = 2000;
  localparam logic [7:0] BOOST_CYCLES = 8'(BOOST_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON = 3'b010,
    ST_OFF = 3'b100
  } ring_state_t;

endpackage

// ### src/ring_gen.sv
// Ringing waveform generator: sine resonator, trapezoid ramp, cadence, register file.
// Assumes tick_1k and tick_8k are one-cycle strobes generated on sys_clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

module ring_gen (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tick_1k,
  input wire logic tick_8k,
  output logic signed [15:0] ring_wave,
  output logic ring_active,
  output logic [2:0] line_state,
  output logic [5:0] ringing_common_mode_level,
  output logic current_limit_boost
);
  import ring_gen_pkg::*;

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh0_7fff) begin
      return 16'sh7fff;
    end else if (v < 18'sh3_8000) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  // Register file state
  logic [7:0] ring_control_reg, ring_control_next;
  logic [15:0] ring_on_timer_reg, ring_on_timer_next;
  logic [15:0] ring_off_timer_reg, ring_off_timer_next;
  logic [2:0] linefeed_state_field_reg, linefeed_state_field_next;
  logic [5:0] high_battery_level_reg, high_battery_level_next;
  logic boost_en_reg, boost_en_next;
  logic [15:0] ind_data_reg, ind_data_next;
  logic [7:0] ind_addr_reg, ind_addr_next;
  logic [15:0] ring_offset_word_reg, ring_offset_word_next;
  logic [15:0] ring_frequency_coeff_reg, ring_frequency_coeff_next;
  logic [15:0] ring_amplitude_word_reg, ring_amplitude_word_next;
  logic [15:0] ring_phase_or_halfperiod_reg, ring_phase_or_halfperiod_next;
  logic [3:0] ring_common_mode_headroom_reg, ring_common_mode_headroom_next;
  logic [7:0] rdata_reg, rdata_next;

  // Engine state
  ring_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic signed [15:0] s1_reg, s1_next;
  logic signed [15:0] s2_reg, s2_next;
  logic [15:0] half_reg, half_next;
  logic dir_up_reg, dir_up_next;
  logic signed [15:0] wave_reg, wave_next;
  logic [5:0] cm_reg, cm_next;
  logic [7:0] boost_cnt_reg, boost_cnt_next;

  logic lf_ring_write;
  logic on_expire;
  logic off_expire;
  logic leave_on;
  logic signed [31:0] res_prod;
  logic signed [17:0] ramp_sum;
  logic signed [15:0] amp_s;
  logic [6:0] cm_diff;

  assign lf_ring_write = reg_wr && reg_addr == ADDR_LINEFEED && reg_wdata[2:0] == LF_RINGING;
  assign amp_s = $signed(ring_amplitude_word_reg);

  // Register bus and indirect space
  always_comb begin
    ring_control_next = ring_control_reg;
    ring_on_timer_next = ring_on_timer_reg;
    ring_off_timer_next = ring_off_timer_reg;
    linefeed_state_field_next = linefeed_state_field_reg;
    high_battery_level_next = high_battery_level_reg;
    boost_en_next = boost_en_reg;
    ind_data_next = ind_data_reg;
    ind_addr_next = ind_addr_reg;
    ring_offset_word_next = ring_offset_word_reg;
    ring_frequency_coeff_next = ring_frequency_coeff_reg;
    ring_amplitude_word_next = ring_amplitude_word_reg;
    ring_phase_or_halfperiod_next = ring_phase_or_halfperiod_reg;
    ring_common_mode_headroom_next = ring_common_mode_headroom_reg;
    rdata_next = RESET_BYTE;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_IND_DATA_LO: ind_data_next[7:0] = reg_wdata;
        ADDR_IND_DATA_HI: ind_data_next[15:8] = reg_wdata;
        ADDR_IND_ADDR: ind_addr_next = reg_wdata;
        ADDR_IND_CMD: begin
          if (reg_wdata[BIT_IND_WRITE]) begin
            unique case (ind_addr_reg)
              IND_OFFSET: ring_offset_word_next = ind_data_reg;
              IND_FREQ: ring_frequency_coeff_next = ind_data_reg;
              IND_AMP: ring_amplitude_word_next = ind_data_reg;
              IND_PHASE: ring_phase_or_halfperiod_next = ind_data_reg;
              IND_HEADROOM: ring_common_mode_headroom_next = ind_data_reg[3:0];
              default: ;
            endcase
          end else begin
            unique case (ind_addr_reg)
              IND_OFFSET: ind_data_next = ring_offset_word_reg;
              IND_FREQ: ind_data_next = ring_frequency_coeff_reg;
              IND_AMP: ind_data_next = ring_amplitude_word_reg;
              IND_PHASE: ind_data_next = ring_phase_or_halfperiod_reg;
              IND_HEADROOM: ind_data_next = {12'h000, ring_common_mode_headroom_reg};
              default: ind_data_next = RESET_WORD;
            endcase
          end
        end
        ADDR_RING_CONTROL: ring_control_next = reg_wdata;
        ADDR_ON_TIMER_LO: ring_on_timer_next[7:0] = reg_wdata;
        ADDR_ON_TIMER_HI: ring_on_timer_next[15:8] = reg_wdata;
        ADDR_OFF_TIMER_LO: ring_off_timer_next[7:0] = reg_wdata;
        ADDR_OFF_TIMER_HI: ring_off_timer_next[15:8] = reg_wdata;
        ADDR_LINEFEED: linefeed_state_field_next = reg_wdata[2:0];
        ADDR_HIGH_BATTERY: high_battery_level_next = reg_wdata[5:0];
        ADDR_EXT_CONTROL: boost_en_next = reg_wdata[BIT_BOOST_EN];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_IND_DATA_LO: rdata_next = ind_data_reg[7:0];
        ADDR_IND_DATA_HI: rdata_next = ind_data_reg[15:8];
        ADDR_IND_ADDR: rdata_next = ind_addr_reg;
        ADDR_RING_CONTROL: begin
          rdata_next = ring_control_reg;
          rdata_next[BIT_OSC_EN] = state_reg == ST_ON;
        end
        ADDR_ON_TIMER_LO: rdata_next = ring_on_timer_reg[7:0];
        ADDR_ON_TIMER_HI: rdata_next = ring_on_timer_reg[15:8];
        ADDR_OFF_TIMER_LO: rdata_next = ring_off_timer_reg[7:0];
        ADDR_OFF_TIMER_HI: rdata_next = ring_off_timer_reg[15:8];
        ADDR_LINEFEED: rdata_next = {5'h00, line_state};
        ADDR_HIGH_BATTERY: rdata_next = {2'h0, high_battery_level_reg};
        ADDR_EXT_CONTROL: rdata_next = {boost_en_reg, 7'h00};
        default: rdata_next = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ring_control_reg <= RESET_BYTE;
      ring_on_timer_reg <= RESET_WORD;
      ring_off_timer_reg <= RESET_WORD;
      linefeed_state_field_reg <= RESET_BYTE[2:0];
      high_battery_level_reg <= RESET_BYTE[5:0];
      boost_en_reg <= 1'b0;
      ind_data_reg <= RESET_WORD;
      ind_addr_reg <= RESET_BYTE;
      ring_offset_word_reg <= RESET_WORD;
      ring_frequency_coeff_reg <= RESET_WORD;
      ring_amplitude_word_reg <= RESET_WORD;
      ring_phase_or_halfperiod_reg <= RESET_WORD;
      ring_common_mode_headroom_reg <= RESET_BYTE[3:0];
      rdata_reg <= RESET_BYTE;
    end else begin
      ring_control_reg <= ring_control_next;
      ring_on_timer_reg <= ring_on_timer_next;
      ring_off_timer_reg <= ring_off_timer_next;
      linefeed_state_field_reg <= linefeed_state_field_next;
      high_battery_level_reg <= high_battery_level_next;
      boost_en_reg <= boost_en_next;
      ind_data_reg <= ind_data_next;
      ind_addr_reg <= ind_addr_next;
      ring_offset_word_reg <= ring_offset_word_next;
      ring_frequency_coeff_reg <= ring_frequency_coeff_next;
      ring_amplitude_word_reg <= ring_amplitude_word_next;
      ring_phase_or_halfperiod_reg <= ring_phase_or_halfperiod_next;
      ring_common_mode_headroom_reg <= ring_common_mode_headroom_next;
      rdata_reg <= rdata_next;
    end
  end

  // Cadence and waveform engine
  assign on_expire = state_reg == ST_ON && tick_8k && ring_control_reg[BIT_ON_EN]
    && cnt_reg >= ring_on_timer_reg;
  assign off_expire = state_reg == ST_OFF && tick_8k && ring_control_reg[BIT_OFF_EN]
    && cnt_reg >= ring_off_timer_reg;
  assign leave_on = state_reg == ST_ON && state_next != ST_ON;
  assign res_prod = $signed(ring_frequency_coeff_reg) * s1_reg;
  // Headroom and battery share the 1.5 V step, so the unscaled difference is in 1.5 V steps
  assign cm_diff = {1'b0, high_battery_level_reg} - {3'h0, ring_common_mode_headroom_reg};

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    s1_next = s1_reg;
    s2_next = s2_reg;
    half_next = half_reg;
    dir_up_next = dir_up_reg;
    cm_next = cm_reg;
    boost_cnt_next = boost_cnt_reg;
    ramp_sum = 18'sd0;
    wave_next = 16'sh0000;
    unique case (state_reg)
      ST_IDLE: begin
        if (lf_ring_write) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (on_expire) begin
          state_next = ST_OFF;
          cnt_next = RESET_WORD;
        end else if (tick_8k) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      ST_OFF: begin
        if (off_expire) begin
          state_next = ST_ON;
        end else if (tick_8k) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (linefeed_state_field_next != LF_RINGING) begin
      state_next = ST_IDLE;
    end
    // Fresh burst: reload oscillator and ramp from the programmed words
    if (state_next == ST_ON && state_reg != ST_ON) begin
      cnt_next = RESET_WORD;
      s1_next = amp_s;
      s2_next = $signed(ring_phase_or_halfperiod_reg);
      half_next = ring_phase_or_halfperiod_reg;
      dir_up_next = 1'b1;
      if (ring_control_reg[BIT_SHAPE]) begin
        s1_next = -amp_s;
      end
    end else if (state_reg == ST_ON && !ring_control_reg[BIT_SHAPE] && tick_1k) begin
      s2_next = s1_reg;
      s1_next = sat16(18'(res_prod >>> 14) - 18'(s2_reg));
    end else if (state_reg == ST_ON && ring_control_reg[BIT_SHAPE] && tick_8k) begin
      if (dir_up_reg) begin
        ramp_sum = 18'(s1_reg) + 18'($signed({1'b0, ring_frequency_coeff_reg}));
      end else begin
        ramp_sum = 18'(s1_reg) - 18'($signed({1'b0, ring_frequency_coeff_reg}));
      end
      if (ramp_sum > 18'(amp_s)) begin
        ramp_sum = 18'(amp_s);
      end else if (ramp_sum < -18'(amp_s)) begin
        ramp_sum = -18'(amp_s);
      end
      s1_next = sat16(ramp_sum);
      if (half_reg <= 16'h0001) begin
        half_next = ring_phase_or_halfperiod_reg;
        dir_up_next = !dir_up_reg;
      end else begin
        half_next = half_reg - 16'h0001;
      end
    end
    // Offset rides only on the active burst
    if (state_reg == ST_ON) begin
      if (ring_control_reg[BIT_OFFSET_EN]) begin
        wave_next = sat16(18'(s1_reg) + 18'($signed(ring_offset_word_reg)));
      end else begin
        wave_next = s1_reg;
      end
    end
    // Common mode latched on entry and held through the cadence
    if (state_reg == ST_IDLE) begin
      cm_next = cm_diff[6] ? 6'h00 : cm_diff[5:0];
    end
    if (state_reg == ST_ON && state_next != ST_ON && boost_en_reg) begin
      boost_cnt_next = BOOST_CYCLES;
    end else if (boost_cnt_reg != 8'h00) begin
      boost_cnt_next = boost_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= RESET_WORD;
      s1_reg <= RESET_WORD;
      s2_reg <= RESET_WORD;
      half_reg <= RESET_WORD;
      dir_up_reg <= 1'b1;
      wave_reg <= RESET_WORD;
      cm_reg <= RESET_BYTE[5:0];
      boost_cnt_reg <= RESET_BYTE;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      half_reg <= half_next;
      dir_up_reg <= dir_up_next;
      wave_reg <= wave_next;
      cm_reg <= cm_next;
      boost_cnt_reg <= boost_cnt_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign ring_wave = wave_reg;
  assign ring_active = state_reg == ST_ON;
  assign line_state = state_reg == ST_ON ? LF_RINGING
    : state_reg == ST_OFF ? LF_ONHOOK_TX : linefeed_state_field_reg;
  assign ringing_common_mode_level = cm_reg;
  assign current_limit_boost = boost_cnt_reg != 8'h00;

  a_ring_entry: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_IDLE && lf_ring_write && !ring_control_reg[BIT_OFFSET_EN]
    |=> state_reg == ST_ON ##1 wave_reg == $past(s1_reg))
    else $error("ringing not entered on linefeed write");
  a_on_expiry: assert property (@(posedge sys_clk) disable iff (rst)
    on_expire && !(reg_wr && reg_addr == ADDR_LINEFEED)
    |=> state_reg == ST_OFF && cnt_reg == 16'h0000 && line_state == LF_ONHOOK_TX ##1 wave_reg == 0)
    else $error("on timer expiry did not stop ringing");
  a_off_restart: assert property (@(posedge sys_clk) disable iff (rst)
    off_expire && !(reg_wr && reg_addr == ADDR_LINEFEED) |=> state_reg == ST_ON)
    else $error("off timer expiry did not restart ringing");
  a_lf_leave: assert property (@(posedge sys_clk) disable iff (rst)
    linefeed_state_field_reg != LF_RINGING && !reg_wr |=> state_reg == ST_IDLE)
    else $error("ringing kept without ringing linefeed");
  a_timer_count: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_ON && tick_8k && !on_expire && state_next == ST_ON
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("cadence counter did not step");
  a_sine_hold: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_ON && $past(state_reg) == ST_ON && !ring_control_reg[BIT_SHAPE]
    && !tick_1k && state_next == ST_ON |=> $stable(s1_reg))
    else $error("sine resonator stepped without 1 kHz strobe");
  a_trap_clamp: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_ON && ring_control_reg[BIT_SHAPE] && $past(state_reg) == ST_ON
    && !amp_s[15] && $stable(ring_amplitude_word_reg) |-> s1_reg <= amp_s && s1_reg >= -amp_s)
    else $error("trapezoid ramp left amplitude limits");
  a_offset_gate: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_ON && !ring_control_reg[BIT_OFFSET_EN] |=> wave_reg == $past(s1_reg))
    else $error("offset applied while disabled");
  a_cm_hold: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != ST_IDLE && $past(state_reg) != ST_IDLE |-> $stable(cm_reg))
    else $error("common mode changed during ringing");
  a_boost_start: assert property (@(posedge sys_clk) disable iff (rst)
    leave_on && boost_en_reg |=> current_limit_boost [*8])
    else $error("current limit boost not raised");
  a_wave_idle: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg != ST_ON |=> wave_reg == 16'sh0000)
    else $error("ringing wave present outside the burst");
  a_trap_reverse: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_ON && ring_control_reg[BIT_SHAPE] && tick_8k && half_reg <= 16'h0001
    |=> dir_up_reg != $past(dir_up_reg) && half_reg == $past(ring_phase_or_halfperiod_reg))
    else $error("trapezoid ramp did not reverse at half period");

endmodule

// ### tb/ring_gen_tb_top.sv
// Self-checking bench for the ringing waveform generator.
// Assumes the bench itself makes sys_clk and both sample strobes.
`timescale 1ns/10ps

module ring_gen_tb_top;
  import ring_gen_pkg::*;

  logic sys_clk;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tick_1k = 1'b0;
  logic tick_8k = 1'b0;
  logic signed [15:0] ring_wave;
  logic ring_active;
  logic [2:0] line_state;
  logic [5:0] ringing_common_mode_level;
  logic current_limit_boost;
  int fails = 0;
  int samples_checked = 0;
  int seed;
  int div = 0;
  int n8 = 0;
  int n1 = 0;
  localparam logic [7:0] RST_ADDRS [7] = '{ADDR_RING_CONTROL, ADDR_LINEFEED, ADDR_HIGH_BATTERY,
    ADDR_ON_TIMER_LO, ADDR_OFF_TIMER_HI, ADDR_EXT_CONTROL, 8'h55};
  localparam logic [7:0] IND_ADDRS [4] = '{IND_OFFSET, IND_FREQ, IND_AMP, IND_PHASE};

  ring_gen DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_1k(tick_1k),
    .tick_8k(tick_8k), .ring_wave(ring_wave), .ring_active(ring_active),
    .line_state(line_state), .ringing_common_mode_level(ringing_common_mode_level),
    .current_limit_boost(current_limit_boost)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // 8 kHz strobe every 16 cycles, 1 kHz strobe on every eighth of them
  always @(posedge sys_clk) begin
    div <= (div + 1) % 128;
    tick_8k <= (div % 16) == 15;
    tick_1k <= div == 127;
    if (tick_8k) n8 <= n8 + 1;
    if (tick_1k) n1 <= n1 + 1;
  end

  function automatic int sine_step(int s1, int s2, int c);
    int t;
    t = ((c * s1) >>> 14) - s2;
    return (t > 32767) ? 32767 : ((t < -32768) ? -32768 : t);
  endfunction

  // Ramp from -amp, clamped, direction flips after every h steps
  function automatic int trap_exp(int k, int amp, int c, int h);
    int v;
    bit up;
    v = -amp;
    up = 1'b1;
    for (int i = 1; i <= k; i++) begin
      v = up ? v + c : v - c;
      v = (v > amp) ? amp : ((v < -amp) ? -amp : v);
      if (i % h == 0) up = !up;
    end
    return v;
  endfunction

  function automatic logic [5:0] cm_exp(logic [5:0] b, logic [3:0] h);
    return (b > {2'b00, h}) ? 6'(b - {2'b00, h}) : 6'h00;
  endfunction

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic ind_wr(input logic [7:0] a, input logic [15:0] v);
    wr(ADDR_IND_DATA_LO, v[7:0]);
    wr(ADDR_IND_DATA_HI, v[15:8]);
    wr(ADDR_IND_ADDR, a);
    wr(ADDR_IND_CMD, 8'h01);
  endtask

  task automatic ind_rd(input logic [7:0] a, output logic [15:0] v);
    wr(ADDR_IND_ADDR, a);
    wr(ADDR_IND_CMD, 8'h00);
    rd(ADDR_IND_DATA_LO, v[7:0]);
    rd(ADDR_IND_DATA_HI, v[15:8]);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic to_tick(input int target);
    while (n8 < target) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  initial begin
    // Whole run needs well under twenty thousand cycles
    #200_000;
    fails++;
    end_of_test();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] h;
    logic [15:0] v;
    logic [15:0] w;
    logic [5:0] bat;
    logic [3:0] hr;
    int s1;
    int s2;
    int t;
    int e0;
    int amp;
    int off;
    seed = 82935;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    chk({13'h0, line_state}, 16'h0000, "line state after reset");
    chk({15'h0, current_limit_boost}, 16'h0000, "boost after reset");
    foreach (RST_ADDRS[i]) begin
      rd(RST_ADDRS[i], d);
      chk({8'h00, d}, 16'h0000, "reset or unmapped read");
    end
    // Battery and headroom, with clamp corners first
    for (int i = 0; i < 4; i++) begin
      bat = (i == 0) ? 6'h00 : ((i == 1) ? 6'h3f : 6'($random(seed)));
      hr = (i == 0) ? 4'hf : ((i == 1) ? 4'h0 : 4'($random(seed)));
      wr(ADDR_HIGH_BATTERY, {2'b00, bat});
      rd(ADDR_HIGH_BATTERY, d);
      chk({8'h00, d}, {10'h000, bat}, "battery readback");
      ind_wr(IND_HEADROOM, {12'h000, hr});
      ind_rd(IND_HEADROOM, w);
      chk(w, {12'h000, hr}, "headroom readback");
      settle(2);
      chk({10'h000, ringing_common_mode_level}, {10'h000, cm_exp(bat, hr)}, "common mode");
    end
    foreach (IND_ADDRS[i]) begin
      v = 16'($random(seed));
      ind_wr(IND_ADDRS[i], v);
      ind_rd(IND_ADDRS[i], w);
      chk(w, v, "indirect readback");
    end
    ind_rd(8'h50, w);
    chk(w, 16'h0000, "unknown indirect read");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'hffff : 16'($random(seed));
      wr(ADDR_ON_TIMER_LO + 8'(2 * i), v[7:0]);
      wr(ADDR_ON_TIMER_HI + 8'(2 * i), v[15:8]);
      rd(ADDR_ON_TIMER_LO + 8'(2 * i), d);
      rd(ADDR_ON_TIMER_HI + 8'(2 * i), h);
      chk({h, d}, v, "cadence timer readback");
    end
    // Sine ringing, timers disabled so the burst stays on
    wr(ADDR_RING_CONTROL, 8'h00);
    amp = ($random(seed) & 16'h0fff) | 16'h0100;
    off = $random(seed) & 16'h03ff;
    ind_wr(IND_FREQ, 16'h7efd);
    ind_wr(IND_AMP, 16'(amp));
    ind_wr(IND_PHASE, 16'h0000);
    ind_wr(IND_OFFSET, 16'(off));
    t = n1;
    while (n1 == t) settle(1);
    wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
    settle(2);
    chk({15'h0, ring_active}, 16'h0001, "burst on after linefeed write");
    chk({13'h0, line_state}, {13'h0, LF_RINGING}, "ringing line state");
    settle(1);
    chk(ring_wave, 16'(amp), "sine start, no offset");
    s1 = amp;
    s2 = 0;
    for (int k = 0; k < 4; k++) begin
      t = n1;
      while (n1 == t) settle(1);
      settle(2);
      t = sine_step(s1, s2, 32'h7efd);
      s2 = s1;
      s1 = t;
      chk(ring_wave, 16'(s1), "sine sample");
    end
    wr(ADDR_LINEFEED, 8'h01);
    settle(2);
    chk({15'h0, ring_active}, 16'h0000, "leave ringing");
    chk(ring_wave, 16'h0000, "wave idle");
    // Trapezoid with offset, clamp and reversal at the seventh step
    wr(ADDR_RING_CONTROL, 8'h03);
    ind_wr(IND_FREQ, 16'd300);
    ind_wr(IND_AMP, 16'd1000);
    ind_wr(IND_PHASE, 16'd7);
    t = n8;
    to_tick(t + 1);
    wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
    settle(3);
    chk(ring_wave, 16'(off - 1000), "trapezoid start with offset");
    for (int k = 1; k <= 8; k++) begin
      t = n8;
      to_tick(t + 1);
      settle(2);
      chk(ring_wave, 16'(trap_exp(k, 1000, 300, 7) + off), "trapezoid ramp");
      if (k == 4) wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
    end
    wr(ADDR_LINEFEED, 8'h01);
    // Cadence: on 3, off 20, boost on leaving the burst
    wr(ADDR_RING_CONTROL, 8'h18);
    wr(ADDR_EXT_CONTROL, 8'h80);
    wr(ADDR_ON_TIMER_LO, 8'h03);
    wr(ADDR_ON_TIMER_HI, 8'h00);
    wr(ADDR_OFF_TIMER_LO, 8'h14);
    wr(ADDR_OFF_TIMER_HI, 8'h00);
    t = n8;
    to_tick(t + 1);
    e0 = n8;
    wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
    settle(2);
    rd(ADDR_RING_CONTROL, d);
    chk({15'h0, d[BIT_OSC_EN]}, 16'h0001, "oscillator status in burst");
    to_tick(e0 + 3);
    settle(2);
    chk({15'h0, ring_active}, 16'h0001, "burst before on timer runs out");
    to_tick(e0 + 4);
    settle(2);
    chk({15'h0, ring_active}, 16'h0000, "burst ends");
    chk(ring_wave, 16'h0000, "wave stopped");
    chk({15'h0, current_limit_boost}, 16'h0001, "boost starts");
    rd(ADDR_LINEFEED, d);
    chk({8'h00, d}, {13'h0, LF_ONHOOK_TX}, "on-hook transmission state");
    settle(185);
    chk({15'h0, current_limit_boost}, 16'h0001, "boost held");
    settle(15);
    chk({15'h0, current_limit_boost}, 16'h0000, "boost over");
    to_tick(e0 + 24);
    settle(2);
    chk({15'h0, ring_active}, 16'h0000, "off period still running");
    to_tick(e0 + 25);
    settle(2);
    chk({15'h0, ring_active}, 16'h0001, "burst restarts");
    chk({13'h0, line_state}, {13'h0, LF_RINGING}, "ringing again");
    wr(ADDR_HIGH_BATTERY, 8'h3f);
    settle(2);
    chk({10'h000, ringing_common_mode_level}, {10'h000, cm_exp(bat, hr)}, "cm held");
    wr(ADDR_LINEFEED, 8'h01);
    settle(2);
    chk({13'h0, line_state}, 16'h0001, "linefeed field shown when idle");
    chk({10'h000, ringing_common_mode_level}, {10'h000, cm_exp(6'h3f, hr)}, "cm idle");
    end_of_test();
  end
endmodule
